// *** core/ssd_sensor.sv ***
// Status, warning, failure and request byte logic of one chained sensor.
`timescale 1ns/1ps
`default_nettype none
`include "ssd_defines.svh"

module ssd_sensor
    import ssd_pkg::*;
#(
    parameter logic [`SSD_TMR_W-1:0] WARN_TIMEOUT_CYC = `SSD_WARN_TIMEOUT_CYC
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [`SSD_ADDR_W-1:0] node_addr_i,
    input wire logic actuator_present_i,
    input wire logic actuator_coded_i,
    input wire logic hysteresis_i,
    input wire logic safety_in_a_i,
    input wire logic safety_in_b_i,
    input wire logic fault_out_a_i,
    input wire logic fault_out_b_i,
    input wire logic fault_cross_i,
    input wire logic fault_temp_i,
    input wire logic fault_actuator_i,
    input wire logic fault_internal_i,
    input wire logic link_fail_i,
    input wire logic serial_diag_input_i,
    input wire logic diag_return_i,
    input wire logic request_valid_i,
    input wire logic [`SSD_ADDR_W-1:0] request_addr_i,
    input wire logic [`SSD_BYTE_W-1:0] request_byte_i,
    output logic safety_out_a_o,
    output logic safety_out_b_o,
    output logic serial_diag_forward_o,
    output logic serial_diag_return_o,
    output logic [`SSD_BYTE_W-1:0] response_byte_o,
    output logic [`SSD_BYTE_W-1:0] warning_byte_o,
    output logic [`SSD_BYTE_W-1:0] failure_byte_o
);

    // -----------------------------------------------------------------------
    // Declarations
    // -----------------------------------------------------------------------
    ssd_state_type state_r;
    ssd_state_type state_nxt;
    logic actuated;
    logic inputs_ok;
    logic release_ok;
    logic warn_any;
    logic hard_fault;
    logic req_hit;
    logic fail_reset;
    logic tmr_run;
    logic tmr_expired;
    logic out_en_nxt;
    logic out_a_r;
    logic out_b_r;
    logic fwd_r;
    logic ret_r;
    logic [`SSD_BYTE_W-1:0] resp_r;
    logic [`SSD_BYTE_W-1:0] resp_nxt;
    logic [`SSD_BYTE_W-1:0] warn_r;
    logic [`SSD_BYTE_W-1:0] warn_nxt;
    logic [`SSD_BYTE_W-1:0] fail_r;
    logic [`SSD_BYTE_W-1:0] fail_cause;

    // -----------------------------------------------------------------------
    // Sensor conditions
    // -----------------------------------------------------------------------
    // A present target only counts when its coding is recognised.
    assign actuated = actuator_present_i && actuator_coded_i;
    // Upstream sensors permit operation only when both channels are live.
    assign inputs_ok = safety_in_a_i && safety_in_b_i;
    assign release_ok = actuated && inputs_ok;
    // Faults that start the switch-off delay rather than acting at once.
    assign warn_any = fault_out_a_i || fault_out_b_i || fault_cross_i ||
        fault_temp_i;
    // Faults that drop the enabling path immediately.
    assign hard_fault = fault_actuator_i || fault_internal_i;

    // -----------------------------------------------------------------------
    // Request byte intake
    // -----------------------------------------------------------------------
    // The gateway relays one byte per chain member; only the byte carrying
    // this sensor's address is taken. Address zero means unassigned, which
    // leaves the 31 usable addresses of a full chain.
    assign req_hit = request_valid_i && (node_addr_i != `SSD_ADDR_NONE) &&
        (request_addr_i == node_addr_i);
    assign fail_reset = req_hit &&
        request_byte_i[`SSD_REQ_FAIL_RESET];

    // -----------------------------------------------------------------------
    // Switch-off delay
    // -----------------------------------------------------------------------
    assign tmr_run = (state_r == SSD_WARN);

    ssd_fault_timer #(
        .LIMIT_CYC(WARN_TIMEOUT_CYC)
    ) u_fault_timer (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .run_i(tmr_run),
        .expired_o(tmr_expired)
    );

    // -----------------------------------------------------------------------
    // Operating state
    // -----------------------------------------------------------------------
    // Hard faults win over everything; a failure only leaves on an explicit
    // reset command once no fault is left, so a fault present in the same
    // cycle as the command keeps the failure latched.
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            SSD_IDLE: begin
                if (hard_fault) begin
                    state_nxt = SSD_FAIL;
                end else if (warn_any) begin
                    state_nxt = SSD_WARN;
                end else if (release_ok) begin
                    state_nxt = SSD_RUN;
                end
            end
            SSD_RUN: begin
                if (hard_fault) begin
                    state_nxt = SSD_FAIL;
                end else if (warn_any) begin
                    state_nxt = SSD_WARN;
                end else if (!release_ok) begin
                    state_nxt = SSD_IDLE;
                end
            end
            SSD_WARN: begin
                if (hard_fault || tmr_expired) begin
                    state_nxt = SSD_FAIL;
                end else if (!warn_any) begin
                    state_nxt = release_ok ? SSD_RUN : SSD_IDLE;
                end
            end
            SSD_FAIL: begin
                if (fail_reset && !hard_fault && !warn_any) begin
                    state_nxt = SSD_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_r <= SSD_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // -----------------------------------------------------------------------
    // Safety outputs
    // -----------------------------------------------------------------------
    // Both channels switch together from one enable; the outputs stay on
    // during the warning delay to allow a controlled stop of the machine.
    assign out_en_nxt = release_ok &&
        ((state_nxt == SSD_RUN) || (state_nxt == SSD_WARN));

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            out_a_r <= 1'b0;
            out_b_r <= 1'b0;
        end else begin
            out_a_r <= out_en_nxt;
            out_b_r <= out_en_nxt;
        end
    end

    assign safety_out_a_o = out_a_r;
    assign safety_out_b_o = out_b_r;

    // -----------------------------------------------------------------------
    // Serial diagnostic chain
    // -----------------------------------------------------------------------
    // The diagnostic line is retimed, not interpreted, on its way through
    // the chain; each sensor adds one cycle of latency in each direction.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            fwd_r <= 1'b0;
            ret_r <= 1'b0;
        end else begin
            fwd_r <= serial_diag_input_i;
            ret_r <= diag_return_i;
        end
    end

    assign serial_diag_forward_o = fwd_r;
    assign serial_diag_return_o = ret_r;

    // -----------------------------------------------------------------------
    // Response byte
    // -----------------------------------------------------------------------
    // Built from the next state so the byte and the outputs change together.
    always_comb begin
        resp_nxt = `SSD_BYTE_ZERO;
        resp_nxt[`SSD_RSP_OUT_ON] = out_en_nxt;
        resp_nxt[`SSD_RSP_ACT_OK] = actuated;
        resp_nxt[`SSD_RSP_RSVD_LO] = 1'b0;
        resp_nxt[`SSD_RSP_RSVD_HI] = 1'b0;
        resp_nxt[`SSD_RSP_IN_OK] = actuated && inputs_ok;
        resp_nxt[`SSD_RSP_HYST] = out_en_nxt && hysteresis_i &&
            (state_nxt == SSD_RUN);
        resp_nxt[`SSD_RSP_WARN] = (state_nxt == SSD_WARN);
        resp_nxt[`SSD_RSP_FAIL] = (state_nxt == SSD_FAIL);
    end

    // -----------------------------------------------------------------------
    // Warning and failure bytes
    // -----------------------------------------------------------------------
    // Warning byte mirrors live faults other than the actuator fault so the controller sees them clear.
    always_comb begin
        warn_nxt = `SSD_BYTE_ZERO;
        warn_nxt[`SSD_DG_OUT_A] = fault_out_a_i;
        warn_nxt[`SSD_DG_OUT_B] = fault_out_b_i;
        warn_nxt[`SSD_DG_CROSS] = fault_cross_i;
        warn_nxt[`SSD_DG_TEMP] = fault_temp_i;
        warn_nxt[`SSD_DG_INTERNAL] = fault_internal_i;
        warn_nxt[`SSD_DG_LINK] = link_fail_i;
    end

    // Causes that may take part in a failure, in failure byte layout.
    always_comb begin
        fail_cause = `SSD_BYTE_ZERO;
        fail_cause[`SSD_DG_OUT_A] = fault_out_a_i;
        fail_cause[`SSD_DG_OUT_B] = fault_out_b_i;
        fail_cause[`SSD_DG_CROSS] = fault_cross_i;
        fail_cause[`SSD_DG_TEMP] = fault_temp_i;
        fail_cause[`SSD_DG_ACTUATOR] = fault_actuator_i;
        fail_cause[`SSD_DG_INTERNAL] = fault_internal_i;
    end

    // The response and warning bytes refresh every cycle without being asked for.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            resp_r <= `SSD_BYTE_ZERO;
            warn_r <= `SSD_BYTE_ZERO;
        end else begin
            resp_r <= resp_nxt;
            warn_r <= warn_nxt;
        end
    end

    // The failure byte is sticky: it keeps the causes of a failure after the
    // fault inputs calm down, so the controller can read why the outputs
    // dropped. Causes are ORed in only while the next state is SSD_FAIL; any other next state clears the byte.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            fail_r <= `SSD_BYTE_ZERO;
        end else if (state_nxt == SSD_FAIL) begin
            fail_r <= fail_r | fail_cause;
        end else begin
            fail_r <= `SSD_BYTE_ZERO;
        end
    end

    assign response_byte_o = resp_r;
    assign warning_byte_o = warn_r;
    assign failure_byte_o = fail_r;

    // -----------------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------------
    a_resp_reserved_zero: assert property (@(posedge clk_sys_i)
        disable iff (rst_i)
        response_byte_o[`SSD_RSP_RSVD_HI:`SSD_RSP_RSVD_LO] == 2'b00)
        else $error("Reserved response bits are not zero.");

    a_outs_match_bit: assert property (@(posedge clk_sys_i)
        disable iff (rst_i)
        (safety_out_a_o == response_byte_o[`SSD_RSP_OUT_ON]) &&
        (safety_out_b_o == safety_out_a_o))
        else $error("Safety outputs disagree with response bit 0.");

    a_fail_outputs_off: assert property (@(posedge clk_sys_i)
        disable iff (rst_i)
        response_byte_o[`SSD_RSP_FAIL] |->
        (!safety_out_a_o && !safety_out_b_o &&
        (state_r == SSD_FAIL)))
        else $error("Outputs on while failure is reported.");

    a_warn_bit_state: assert property (@(posedge clk_sys_i)
        disable iff (rst_i)
        response_byte_o[`SSD_RSP_WARN] == (state_r == SSD_WARN))
        else $error("Warning bit does not track the warning state.");

    a_no_actuator_zero: assert property (@(posedge clk_sys_i)
        disable iff (rst_i)
        (!actuator_present_i && !warn_any && !hard_fault &&
        (state_r != SSD_FAIL)) |=>
        (response_byte_o == `SSD_BYTE_ZERO) && !safety_out_a_o)
        else $error("Response not zero with no actuator present.");

    a_released_pattern: assert property (@(posedge clk_sys_i)
        disable iff (rst_i)
        ((state_r == SSD_RUN) && release_ok && !hysteresis_i &&
        !warn_any && !hard_fault) |=>
        (response_byte_o == `SSD_RSP_RUN_PATTERN) && safety_out_b_o)
        else $error("Released sensor response pattern is wrong.");

    a_warn_to_fail: assert property (@(posedge clk_sys_i)
        disable iff (rst_i)
        ((state_r == SSD_WARN) && tmr_expired) |=>
        ((state_r == SSD_FAIL) && !safety_out_a_o))
        else $error("Expired warning did not switch the outputs off.");

    a_fail_reset_ok: assert property (@(posedge clk_sys_i)
        disable iff (rst_i)
        ((state_r == SSD_FAIL) && fail_reset && !warn_any &&
        !hard_fault) |=> ((state_r == SSD_IDLE) &&
        !response_byte_o[`SSD_RSP_FAIL]))
        else $error("Failure reset command was not obeyed.");

    a_fail_holds: assert property (@(posedge clk_sys_i)
        disable iff (rst_i)
        ((state_r == SSD_FAIL) && !fail_reset) |=> (state_r == SSD_FAIL))
        else $error("Failure left without a reset command.");

    a_chain_forward: assert property (@(posedge clk_sys_i)
        disable iff (rst_i)
        $rose(serial_diag_input_i) |=> serial_diag_forward_o)
        else $error("Diagnostic line not passed to the next sensor.");

    a_link_warn_bit: assert property (@(posedge clk_sys_i)
        disable iff (rst_i)
        link_fail_i |=> warning_byte_o[`SSD_DG_LINK])
        else $error("Gateway link failure not flagged.");

    a_hard_fault_fast: assert property (@(posedge clk_sys_i)
        disable iff (rst_i)
        fault_actuator_i |=> (response_byte_o[`SSD_RSP_FAIL] &&
        failure_byte_o[`SSD_DG_ACTUATOR]))
        else $error("Actuator fault did not latch a failure.");

    a_inputs_bit: assert property (@(posedge clk_sys_i)
        disable iff (rst_i)
        (actuated && !inputs_ok) |=> !response_byte_o[`SSD_RSP_IN_OK])
        else $error("Input bit set with a chained channel off.");

endmodule
`default_nettype wire

// *** core/ssd_defines.svh ***
// Bit positions, patterns and timing constants of the sensor diagnostic bytes.
`ifndef SSD_DEFINES_SVH
`define SSD_DEFINES_SVH

// ---------------------------------------------------------------------------
// Chain addressing
// ---------------------------------------------------------------------------
`define SSD_ADDR_W 5
`define SSD_ADDR_NONE 5'h00
`define SSD_BYTE_W 8
`define SSD_BYTE_ZERO 8'h00

// ---------------------------------------------------------------------------
// Request byte fields
// ---------------------------------------------------------------------------
`define SSD_REQ_FAIL_RESET 7

// ---------------------------------------------------------------------------
// Response byte fields
// ---------------------------------------------------------------------------
`define SSD_RSP_OUT_ON 0
`define SSD_RSP_ACT_OK 1
`define SSD_RSP_RSVD_LO 2
`define SSD_RSP_RSVD_HI 3
`define SSD_RSP_IN_OK 4
`define SSD_RSP_HYST 5
`define SSD_RSP_WARN 6
`define SSD_RSP_FAIL 7
`define SSD_RSP_RUN_PATTERN 8'h13

// ---------------------------------------------------------------------------
// Warning and failure diagnostic byte fields
// ---------------------------------------------------------------------------
`define SSD_DG_OUT_A 0
`define SSD_DG_OUT_B 1
`define SSD_DG_CROSS 2
`define SSD_DG_TEMP 3
`define SSD_DG_ACTUATOR 4
`define SSD_DG_INTERNAL 5
`define SSD_DG_LINK 6
`define SSD_DG_SPARE 7

// ---------------------------------------------------------------------------
// Switch-off delay after a warning fault
// ---------------------------------------------------------------------------
`define SSD_TMR_W 36
`define SSD_CLK_HZ 25000000
`define SSD_SEC_PER_MIN 60
`define SSD_WARN_TIMEOUT_MIN 30
`define SSD_WARN_TIMEOUT_CYC (36'(`SSD_WARN_TIMEOUT_MIN) * \
    36'(`SSD_SEC_PER_MIN) * 36'(`SSD_CLK_HZ))
`define SSD_TMR_ZERO 36'h0
`define SSD_TMR_ONE 36'h1

`endif

// *** core/ssd_pkg.sv ***
// Types shared by the sensor diagnostic logic.
package ssd_pkg;

    // -----------------------------------------------------------------------
    // Operating states of the sensor
    // -----------------------------------------------------------------------
    typedef enum logic [1:0] {
        SSD_IDLE = 2'b00,
        SSD_RUN  = 2'b01,
        SSD_WARN = 2'b10,
        SSD_FAIL = 2'b11
    } ssd_state_type;

endpackage

// *** core/ssd_fault_timer.sv ***
// Switch-off delay counter that runs while a warning fault is pending.
`timescale 1ns/1ps
`default_nettype none
`include "ssd_defines.svh"

module ssd_fault_timer #(
    parameter logic [`SSD_TMR_W-1:0] LIMIT_CYC = `SSD_WARN_TIMEOUT_CYC
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic run_i,
    output logic expired_o
);

    logic [`SSD_TMR_W-1:0] cnt_r;

    // -----------------------------------------------------------------------
    // Counter
    // -----------------------------------------------------------------------
    // Restarts from zero whenever the warning goes away, so a new fault gets
    // the full delay; the count saturates to avoid wrapping back to safe.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || !run_i) begin
            cnt_r <= `SSD_TMR_ZERO;
        end else if (!expired_o) begin
            cnt_r <= cnt_r + `SSD_TMR_ONE;
        end
    end

    // Expiry one cycle early so the registered outputs drop within the limit.
    assign expired_o = run_i && (cnt_r >= LIMIT_CYC - `SSD_TMR_ONE);

    a_timer_bound: assert property (@(posedge clk_sys_i)
        disable iff (rst_i) cnt_r <= LIMIT_CYC)
        else $error("Switch-off delay counter ran past its limit.");

endmodule
`default_nettype wire

// *** verification/ssd_gateway_model.sv ***
// Behavioural fieldbus gateway: sends request bytes and drives the diag line.
`timescale 1ns/1ps
`default_nettype none
`include "ssd_defines.svh"

module ssd_gateway_model (
    input wire logic clk_sys_i,
    output logic request_valid_o,
    output logic [`SSD_ADDR_W-1:0] request_addr_o,
    output logic [`SSD_BYTE_W-1:0] request_byte_o,
    output logic serial_diag_o
);
    // -----------------------------------------------------------------------
    // Request side
    // -----------------------------------------------------------------------
    // Idle address and byte are inverted so a stale request is never reused.
    initial begin
        request_valid_o = 1'b0;
        request_addr_o = 5'h1f;
        request_byte_o = 8'hff;
    end

    // The diag line moves every cycle, off the sampling edge.
    always @(negedge clk_sys_i) begin
        serial_diag_o <= 1'($urandom);
    end

    // One byte to one addressed sensor, strobe high for one cycle.
    task automatic send(input logic [4:0] addr, input logic [7:0] data);
        @(negedge clk_sys_i);
        request_valid_o = 1'b1;
        request_addr_o = addr;
        request_byte_o = data;
        @(negedge clk_sys_i);
        request_valid_o = 1'b0;
        request_addr_o = ~addr;
        request_byte_o = ~data;
    endtask
endmodule
`default_nettype wire

// *** verification/test_safety_sensor_serial_diag_status.sv ***
// Self-checking bench for the chained sensor status and diagnostic bytes.
`timescale 1ns/1ps
`default_nettype none
`include "ssd_defines.svh"

module test_safety_sensor_serial_diag_status;
    // Short switch-off delay so the warning timeout is reached quickly.
    localparam logic [35:0] LIM = 36'h14;
    logic clk_sys_i, rst_i, act_p, act_c, hyst, in_a, in_b;
    logic [4:0] node_addr;
    logic [3:0] wf;
    logic f_act, f_int, link_fail, diag_ret, req_v, gw_diag;
    logic [4:0] req_a;
    logic [7:0] req_b, rsp, warn_b, fail_b;
    logic out_a, out_b, fwd, ret, s_in, s_ret;
    int fails, n_compared, n;

    ssd_gateway_model gw (.clk_sys_i(clk_sys_i), .request_valid_o(req_v),
        .request_addr_o(req_a), .request_byte_o(req_b),
        .serial_diag_o(gw_diag));

    ssd_sensor #(.WARN_TIMEOUT_CYC(LIM)) uut (.clk_sys_i(clk_sys_i),
        .rst_i(rst_i), .node_addr_i(node_addr), .actuator_present_i(act_p),
        .actuator_coded_i(act_c), .hysteresis_i(hyst),
        .safety_in_a_i(in_a), .safety_in_b_i(in_b), .fault_out_a_i(wf[0]),
        .fault_out_b_i(wf[1]), .fault_cross_i(wf[2]), .fault_temp_i(wf[3]),
        .fault_actuator_i(f_act), .fault_internal_i(f_int),
        .link_fail_i(link_fail), .serial_diag_input_i(gw_diag),
        .diag_return_i(diag_ret), .request_valid_i(req_v),
        .request_addr_i(req_a), .request_byte_i(req_b),
        .safety_out_a_o(out_a), .safety_out_b_o(out_b),
        .serial_diag_forward_o(fwd), .serial_diag_return_o(ret),
        .response_byte_o(rsp), .warning_byte_o(warn_b),
        .failure_byte_o(fail_b));

    // -----------------------------------------------------------------------
    // Clock, helpers and verdict
    // -----------------------------------------------------------------------
    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One cycle; the diag lines are checked on every pass as they never rest.
    task automatic step();
        @(posedge clk_sys_i);
        s_in = gw_diag;
        s_ret = diag_ret;
        @(negedge clk_sys_i);
        diag_ret = 1'($urandom);
        chk({fwd, ret}, {s_in, s_ret});
    endtask

    // Response while actuated with both chained inputs energised.
    function automatic logic [7:0] exp_rsp(input logic fl, wn, hy, on);
        return {fl, wn, hy, 1'b1, 2'b00, 1'b1, on};
    endfunction

    task automatic report_and_stop();
        if (fails == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // A full pass takes far less than this span, so running out means a hang.
    initial begin
        #(40 * 4000);
        fails++;
        report_and_stop();
    end

    // -----------------------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------------------
    initial begin
        void'($urandom(32'h1c92));
        {act_p, act_c, hyst, in_a, in_b, f_act, f_int, link_fail} = 8'h00;
        {wf, diag_ret, rst_i} = 6'h01;
        fails = 0;
        n_compared = 0;
        node_addr = 5'($urandom_range(31, 1));
        repeat (6) @(negedge clk_sys_i);
        rst_i = 1'b0;
        // Nothing in range: random side inputs must leave the response byte and both outputs at zero.
        repeat (30) begin
            {act_c, hyst, in_a, in_b} = 4'($urandom);
            step();
            chk(rsp, 8'h00);
            chk({6'h00, out_a, out_b}, 8'h00);
        end
        {act_p, act_c, in_a, in_b, hyst} = 5'h1e;
        step();
        chk(rsp, exp_rsp(0, 0, 0, 1));
        chk({out_a, out_b, warn_b, fail_b}, {2'b11, 16'h0});
        hyst = 1'b1;
        step();
        chk(rsp, exp_rsp(0, 0, 1, 1));
        hyst = 1'b0;
        in_b = 1'b0;
        step();
        chk(8'(rsp[4]), 8'h00);
        in_b = 1'b1;
        step();
        step();
        chk(rsp, exp_rsp(0, 0, 0, 1));
        for (int i = 0; i < 4; i++) begin
            wf = 4'h1 << i;
            step();
            chk(rsp, exp_rsp(0, 1, 0, 1));
            chk(warn_b, {4'h0, wf});
            wf = 4'h0;
            step();
            chk(rsp, exp_rsp(0, 0, 0, 1));
        end
        link_fail = 1'b1;
        step();
        chk(warn_b, 8'h40);
        link_fail = 1'b0;
        step();
        step();
        // Warning left standing must end in failure within the delay.
        wf = 4'h8;
        n = 0;
        while (rsp[7] !== 1'b1 && n < 40) begin
            step();
            n++;
        end
        chk(8'(n > 10 && n <= 21), 8'h01);
        chk(rsp, exp_rsp(1, 0, 0, 0));
        chk({out_a, out_b, fail_b}, {2'b00, 8'h08});
        wf = 4'h0;
        step();
        chk(rsp, exp_rsp(1, 0, 0, 0));
        // Wrong address, unassigned address and bit 7 clear are all ignored.
        gw.send((node_addr == 5'h1f) ? 5'h01 : node_addr + 5'h01, 8'h80);
        gw.send(5'h00, 8'h80);
        gw.send(node_addr, 8'h7f);
        chk(rsp, exp_rsp(1, 0, 0, 0));
        gw.send(node_addr, 8'h80);
        chk({rsp[7], fail_b}, 9'h0);
        step();
        chk(rsp, exp_rsp(0, 0, 0, 1));
        // Immediate failures; a reset while the fault stands is refused.
        for (int k = 0; k < 2; k++) begin
            {f_int, f_act} = 2'b01 << k;
            step();
            chk(rsp, exp_rsp(1, 0, 0, 0));
            chk(fail_b, (k == 0) ? 8'h10 : 8'h20);
            chk(warn_b, (k == 0) ? 8'h00 : 8'h20);
            gw.send(node_addr, 8'h80);
            chk(8'(rsp[7]), 8'h01);
            {f_int, f_act} = 2'b00;
            gw.send(node_addr, 8'h80);
            step();
            chk(rsp, exp_rsp(0, 0, 0, 1));
        end
        // Faults without an actuator: warning, then a hard fault on top.
        {act_p, wf} = 5'h01;
        step();
        chk(rsp, 8'h40);
        f_int = 1'b1;
        step();
        chk({rsp, fail_b, warn_b}, 24'h802121);
        {f_int, wf} = 5'h00;
        gw.send(node_addr, 8'h80);
        chk({rsp, fail_b}, 16'h0000);
        act_p = 1'b1;
        step();
        chk(rsp, exp_rsp(0, 0, 0, 1));
        rst_i = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        chk(rsp, 8'h00);
        rst_i = 1'b0;
        step();
        chk(rsp, exp_rsp(0, 0, 0, 1));
        report_and_stop();
    end
endmodule
`default_nettype wire
